// File: rtl/szb_branch_unit.sv
`timescale 1ns/1ps
`include "szb_defs.svh"
// How it works
// RULE_01 - Positive families branch when test value above zero.
// RULE_02 - Nonpositive families branch when value at most zero.
// RULE_03 - Negative families branch when value below zero.
// RULE_04 - Register form target is PC plus offset register.
// RULE_05 - Literal form target is PC plus extended literal.
// RULE_06 - Not taken: PC plus four, one cycle.
// RULE_07 - Slot set: next instruction completes before target.
// RULE_08 - Slot clear and taken: squash following instruction.
// RULE_09 - Slot variants equal base forms except slot bit.
// RULE_10 - Taken with slot takes two cycles.
// RULE_11 - Taken without slot takes three cycles.
// RULE_12 - Literal sign-extended from sixteen to thirty-two bits.
// RULE_13 - Prefix supplies upper half instead of extension.
// RULE_14 - Only PC changes; no register write.
// RULE_15 - Opcode bits 0-5, slot bit 6, condition 7-10.
// RULE_16 - Signed compare; PC is the branch's own address.
module szb_branch_unit
    import szb_pkg::*;
#(
    parameter int LIT_W = 16,
    parameter int WORD_W = 32
)
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic issue_i,
    input wire logic [31:0] instr_i,
    input wire logic [31:0] pc_i,
    input wire logic [31:0] test_source_reg_i,
    input wire logic [31:0] offset_source_reg_i,
    input wire logic prefix_valid_i,
    input wire logic [15:0] prefix_upper_i,
    output logic accept_o,
    output logic busy_o,
    output logic done_o,
    output logic pc_load_o,
    output logic [31:0] next_pc_o,
    output logic taken_o,
    output logic squash_next_o,
    output logic slot_keep_o,
    output logic [1:0] latency_o,
    output logic reg_write_o
);
    // All state sits in one record so that reset clears it in one step.
    typedef struct packed {
        szb_phase_t phase;
        logic [1:0] left;
        logic done;
        logic pc_load;
        logic [31:0] next_pc;
        logic taken;
        logic squash;
        logic keep;
        logic [1:0] latency;
    } szb_state_t;

    szb_state_t st;
    szb_state_t next_st;
    szb_dec_if dif();
    logic go;
    logic cond;
    logic [31:0] offset;
    logic signed [31:0] tv;
    logic [31:0] lit_ext;

    // The prefix half and the literal must tile one word exactly;
    // any other split would leave target bits undriven.
    if (WORD_W != 32) begin : g_bad_word
        $error("szb_branch_unit: WORD_W must be 32");
    end
    if (LIT_W * 2 != WORD_W) begin : g_bad_lit
        $error("szb_branch_unit: LIT_W must be half of WORD_W");
    end

    // RULE_12 literal sign extension
    for (genvar gi = 0; gi < WORD_W; gi++) begin : g_ext
        if (gi < LIT_W) begin : g_low
            assign lit_ext[gi] = instr_i[gi];
        end else begin : g_high
            assign lit_ext[gi] = instr_i[LIT_W-1];
        end
    end

    // RULE_16 sign bit based zero test
    // Testing the sign bit and a reduction avoids a signed compare against
    // an unsized zero, which some tools silently make unsigned.
    function automatic logic szb_cond_met(input szb_cmp_t c,
        input logic [WORD_W-1:0] v);
        logic neg;
        logic zero;
        logic hit;
        neg = v[WORD_W-1];
        zero = ~|v;
        hit = 1'b0;
        case (c)
            // RULE_01 strictly above zero
            SZB_CMP_GT: hit = !neg && !zero;
            // RULE_02 zero or below
            SZB_CMP_LE: hit = neg || zero;
            // RULE_03 strictly below zero
            SZB_CMP_LT: hit = neg;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // RULE_04 RULE_06 next program counter
    function automatic logic [WORD_W-1:0] szb_target(
        input logic [WORD_W-1:0] pc,
        input logic [WORD_W-1:0] off,
        input logic take);
        logic [WORD_W-1:0] sum;
        if (take) begin
            sum = pc + off;
        end else begin
            sum = pc + `SZB_PC_STEP;
        end
        return sum;
    endfunction

    // RULE_10 RULE_11 taken latency
    function automatic logic [1:0] szb_taken_lat(input logic slot);
        logic [1:0] lat;
        lat = slot ? `SZB_LAT_SLOT : `SZB_LAT_NOSLOT;
        return lat;
    endfunction

    szb_decode u_dec (
        .instr_i(instr_i),
        .dec(dif.dec)
    );

    // An issue is refused while a taken branch waits; the fetch stage
    // must hold it, since nothing here queues a second branch.
    assign go = issue_i && dif.hit && (st.phase == SZB_IDLE);
    assign accept_o = go;
    assign busy_o = (st.phase != SZB_IDLE);
    assign done_o = st.done;
    assign pc_load_o = st.pc_load;
    assign next_pc_o = st.next_pc;
    assign taken_o = st.taken;
    assign squash_next_o = st.squash;
    assign slot_keep_o = st.keep;
    assign latency_o = st.latency;
    // RULE_14 no register write
    assign reg_write_o = 1'b0;

    always_comb begin
        // RULE_16 signed test value
        tv = $signed(test_source_reg_i);
        cond = szb_cond_met(dif.cmp, tv);
        if (dif.lit_form) begin
            // RULE_13 prefix upper half
            if (prefix_valid_i) begin
                offset = {prefix_upper_i, instr_i[LIT_W-1:0]};
            end else begin
                // RULE_12 sign extension
                offset = lit_ext;
            end
        end else begin
            offset = offset_source_reg_i;
        end
    end

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.pc_load = 1'b0;
        case (st.phase)
            SZB_IDLE: begin
                if (go) begin
                    next_st.taken = cond;
                    next_st.keep = dif.slot;
                    if (!cond) begin
                        // A falling-through branch never enters the wait.
                        // RULE_06 fall through in one cycle
                        next_st.next_pc = szb_target(pc_i, offset, 1'b0);
                        next_st.pc_load = 1'b1;
                        next_st.done = 1'b1;
                        next_st.squash = 1'b0;
                        next_st.latency = `SZB_LAT_FALL;
                    end else begin
                        // RULE_04 RULE_05 relative target from own PC
                        next_st.next_pc = szb_target(pc_i, offset, 1'b1);
                        // RULE_07 RULE_08 slot handling
                        next_st.squash = !dif.slot;
                        // RULE_10 RULE_11 taken latency
                        next_st.latency = szb_taken_lat(dif.slot);
                        next_st.left = next_st.latency - `SZB_LAT_FALL;
                        next_st.phase = SZB_WAIT;
                    end
                end
            end
            SZB_WAIT: begin
                // Count down the cycles left before the target loads.
                next_st.left = st.left - `SZB_LAT_FALL;
                if (st.left == `SZB_LAT_FALL) begin
                    next_st.pc_load = 1'b1;
                    next_st.done = 1'b1;
                    next_st.phase = SZB_IDLE;
                end
            end
            default: next_st.phase = SZB_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        // Reset clears every flag, so no stale load follows reset.
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// File: rtl/szb_defs.svh
`ifndef SZB_DEFS_SVH
`define SZB_DEFS_SVH
`define SZB_OPC_REG 6'h27
`define SZB_OPC_LIT 6'h2F
`define SZB_CND_GT 4'h4
`define SZB_CND_LE 4'h3
`define SZB_CND_LT 4'h2
`define SZB_PC_STEP 32'h0000_0004
`define SZB_LAT_SLOT 2'h2
`define SZB_LAT_NOSLOT 2'h3
`define SZB_LAT_FALL 2'h1
`endif

// File: rtl/szb_pkg.sv
package szb_pkg;
    typedef enum logic [1:0] {SZB_CMP_GT, SZB_CMP_LE, SZB_CMP_LT, SZB_CMP_NONE}
        szb_cmp_t;
    typedef enum logic [1:0] {SZB_IDLE, SZB_WAIT} szb_phase_t;
endpackage

// File: rtl/szb_dec_if.sv
`timescale 1ns/1ps
interface szb_dec_if;
    import szb_pkg::*;
    logic hit;
    logic lit_form;
    logic slot;
    szb_cmp_t cmp;
    modport dec (output hit, output lit_form, output slot, output cmp);
    modport use_side (input hit, input lit_form, input slot, input cmp);
endinterface

// File: rtl/szb_decode.sv
`timescale 1ns/1ps
`include "szb_defs.svh"
module szb_decode
    import szb_pkg::*;
(
    input wire logic [31:0] instr_i,
    szb_dec_if.dec dec
);
    // Bit 0 is the most significant instruction bit.
    function automatic logic [31:0] szb_flip(input logic [31:0] w);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            r[i] = w[31 - i];
        end
        return r;
    endfunction

    logic [31:0] f;
    logic [5:0] opc;
    logic [3:0] cnd;

    always_comb begin
        f = szb_flip(instr_i);
        opc = {f[0], f[1], f[2], f[3], f[4], f[5]};
        cnd = {f[7], f[8], f[9], f[10]};
        // RULE_15 opcode field decode
        dec.lit_form = (opc == `SZB_OPC_LIT);
        // RULE_09 slot bit only
        dec.slot = f[6];
        case (cnd)
            `SZB_CND_GT: dec.cmp = SZB_CMP_GT;
            `SZB_CND_LE: dec.cmp = SZB_CMP_LE;
            `SZB_CND_LT: dec.cmp = SZB_CMP_LT;
            default: dec.cmp = SZB_CMP_NONE;
        endcase
        dec.hit = ((opc == `SZB_OPC_REG) || (opc == `SZB_OPC_LIT))
            && (dec.cmp != SZB_CMP_NONE);
    end
endmodule

// File: verification/szb_fetch_model.sv
`timescale 1ns/1ps
module szb_fetch_model (
    input wire logic [5:0] opc_i,
    input wire logic slot_i,
    input wire logic [3:0] cond_i,
    input wire logic [15:0] low_i,
    output logic [31:0] instr_o
);
    assign instr_o = {opc_i, slot_i, cond_i, 5'h00, low_i};
endmodule

// File: verification/szb_chk.sv
`timescale 1ns/1ps
module szb_chk (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic accept_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic pc_load_o,
    input wire logic taken_o,
    input wire logic squash_next_o,
    input wire logic slot_keep_o,
    input wire logic [1:0] latency_o,
    input wire logic reg_write_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    pair_load_a: assert property (done_o == pc_load_o)
        else $error("load mismatch");
    fall_lat_a: assert property (accept_o ##1 !taken_o |->
        done_o && latency_o == 2'h1) else $error("fall latency");
    slot_lat_a: assert property (accept_o ##1 (taken_o && slot_keep_o)
        |-> !done_o ##1 (done_o && latency_o == 2'h2)) else $error("slot");
    wait_lat_a: assert property (accept_o ##1 (taken_o && !slot_keep_o)
        |-> !done_o[*2] ##1 (done_o && latency_o == 2'h3)) else $error("wait");
    squash_sel_a: assert property (done_o |->
        squash_next_o == (taken_o && !slot_keep_o)) else $error("squash");
    busy_hold_a: assert property (accept_o ##1 taken_o |-> busy_o)
        else $error("busy");
    busy_refuse_a: assert property (busy_o |-> !accept_o)
        else $error("accepted while busy");
    no_write_a: assert property (!reg_write_o)
        else $error("register write");
endmodule
bind szb_branch_unit szb_chk chk (.*);

// File: verification/szb_branch_unit_bench.sv
`timescale 1ns/1ps
`include "szb_defs.svh"
`define CK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module szb_branch_unit_bench;
    logic clk = 0, rst_n = 0, iss = 0, slot = 0, pv = 0, acc, done, tkn, sq;
    logic [5:0] opc = '0;
    logic [3:0] cnd = '0;
    logic [15:0] lo = '0, up = '0;
    logic [31:0] tsr = '0, ins, npc;
    logic [1:0] lat;
    int err_count = 0, n_tests = 0;
    always #5 clk = ~clk;
    szb_fetch_model fm (.opc_i(opc), .slot_i(slot), .cond_i(cnd),
        .low_i(lo), .instr_o(ins));
    szb_branch_unit dut (.ref_clk_i(clk), .rst_n_i(rst_n), .issue_i(iss),
        .instr_i(ins), .pc_i(32'h0000_1000), .test_source_reg_i(tsr),
        .offset_source_reg_i(32'h0000_0100), .prefix_valid_i(pv),
        .prefix_upper_i(up), .accept_o(acc), .busy_o(), .done_o(done),
        .pc_load_o(), .next_pc_o(npc), .taken_o(tkn), .squash_next_o(sq),
        .slot_keep_o(), .latency_o(lat), .reg_write_o());
    task automatic end_of_test;
        if (err_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Target equal to pc plus four marks a branch expected to fall through.
    task automatic br(input logic [5:0] o, input logic s, input logic [3:0] c,
        input logic [31:0] a, input logic [15:0] l, input logic [31:0] t);
        int n;
        logic tk;
        tk = (t !== 32'h0000_1004);
        @(posedge clk);
        opc <= o;
        slot <= s;
        cnd <= c;
        tsr <= a;
        lo <= l;
        iss <= 1'b1;
        #1;
        `CK("accept", 1'b1, acc)
        @(posedge clk);
        iss <= 1'b0;
        n = 1;
        #1;
        while (done !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (done !== 1'b1) begin
            err_count++;
            end_of_test();
        end
        `CK("next_pc", t, npc)
        `CK("taken", tk, tkn)
        `CK("latency", tk ? (s ? 2'h2 : 2'h3) : 2'h1, lat)
        `CK("squash", tk && !s, sq)
        `CK("cycles", tk ? (s ? 2 : 3) : 1, n)
    endtask
    task automatic t_gt;
        br(`SZB_OPC_REG, 0, `SZB_CND_GT, 1, 0, 32'h1100);
        br(`SZB_OPC_LIT, 1, `SZB_CND_GT, 0, 16'h10, 32'h1004);
        br(`SZB_OPC_LIT, 1, `SZB_CND_GT, 32'h8000_0000, 0, 32'h1004);
    endtask
    task automatic t_le;
        br(`SZB_OPC_REG, 1, `SZB_CND_LE, 0, 0, 32'h1100);
        br(`SZB_OPC_LIT, 0, `SZB_CND_LE, 1, 16'hFFF0, 32'h1004);
        br(`SZB_OPC_LIT, 0, `SZB_CND_LE, '1, 16'hFFF0, 32'h0FF0);
    endtask
    task automatic t_lt;
        br(`SZB_OPC_REG, 0, `SZB_CND_LT, 0, 0, 32'h1004);
        br(`SZB_OPC_LIT, 1, `SZB_CND_LT, '1, 16'h20, 32'h1020);
    endtask
    task automatic t_pre;
        @(posedge clk);
        pv <= 1'b1;
        up <= 16'h0002;
        br(`SZB_OPC_LIT, 0, `SZB_CND_GT, 5, 16'h8000, 32'h0002_9000);
        @(posedge clk);
        pv <= 1'b0;
    endtask
    task automatic t_bad;
        @(posedge clk);
        cnd <= 4'h5;
        iss <= 1'b1;
        #1;
        `CK("accept", 1'b0, acc)
        @(posedge clk);
        iss <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_gt();
        t_le();
        t_lt();
        t_pre();
        t_bad();
        end_of_test();
    end
endmodule
